// ==== common/amp_regs_pkg.sv ====
// amp_regs_pkg: offsets, field positions, reset values for the amplifier control registers
// assumes word-aligned AHB-Lite access, 32-bit data, registers in the low byte
package amp_regs_pkg;
  // register indexes as printed; byte address is four times the index
  localparam logic [7:0] IDX_IDENT = 8'h01;
  localparam logic [7:0] IDX_ERRORS = 8'h02;
  localparam logic [7:0] IDX_FILTER = 8'h03;
  localparam logic [7:0] IDX_FORMAT = 8'h04;
  localparam logic [7:0] IDX_SHUTDOWN = 8'h05;
  localparam logic [7:0] IDX_QUIET = 8'h06;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h11;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h12;
  // error flag positions
  localparam int ERR_MCLK = 7;
  localparam int ERR_PLL = 6;
  localparam int ERR_BCLK = 5;
  localparam int ERR_FCLK = 4;
  localparam int ERR_SLIP = 3;
  localparam int ERR_CLIP = 2;
  localparam int ERR_FAULT = 1;
  localparam logic [7:0] ERR_MASK = 8'hfe;
  // control field positions
  localparam int FLT_DCBLOCK = 7;
  localparam int FLT_HARDUNMUTE = 5;
  localparam logic [7:0] FLT_MASK = 8'ha3;
  localparam logic [7:0] FMT_MASK = 8'h0f;
  localparam logic [3:0] FMT_MAX = 4'h8;
  localparam int SHD_MIDZ = 7;
  localparam int SHD_SHUTDOWN = 6;
  localparam int SHD_TERNARY = 3;
  localparam int SHD_FAULTOUT = 1;
  localparam logic [7:0] SHD_MASK = 8'hca;
  localparam logic [7:0] QUIET_MASK = 8'h07;
  // reset values
  localparam logic [7:0] RST_FILTER = 8'h80;
  localparam logic [7:0] RST_FORMAT = 8'h05;
  localparam logic [7:0] RST_SHUTDOWN = 8'h40;
  localparam logic [7:0] RST_QUIET = 8'h00;
  localparam logic [7:0] RST_ERRORS = 8'h00;
  // identification byte, arbitrary value
  localparam logic [7:0] IDENT_VALUE = 8'h00;
  // de-emphasis codes
  localparam logic [1:0] DEEMPH_NONE = 2'h0;
  localparam logic [1:0] DEEMPH_32K = 2'h1;
  localparam logic [1:0] DEEMPH_44K = 2'h2;
  localparam logic [1:0] DEEMPH_48K = 2'h3;
  // serial format families
  typedef enum logic [1:0] {FMT_RIGHT, FMT_I2S, FMT_LEFT} fmt_family_t;
endpackage : amp_regs_pkg

// ==== rtl/amp_control_status_regs.sv ====
// amp_control_status_regs: control and sticky status registers of the amplifier
// assumes event inputs from pins or other clocks (synchronised here), AHB-Lite slave
// Operation
// - error flags stay set until software clears
// - master clock count change sets bit 7
// - bit clock count change sets bit 5
// - frame clock rate change sets bit 4
// - frame slip sets bit 3
// - pll bit 6, clip bit 2, fault bit 1
// - bit 7 enables dc-blocking filter
// - bit 5 selects hard or ramped unmute
// - two-bit de-emphasis selects rate
// - low nibble selects serial format
// - format resets to i2s 24, reserved codes
// - shutdown bit holds hard mute
// - ternary modulation enable bit
// - fault pin direction bit
// - per-channel soft mute bits
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module amp_control_status_regs
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // error events from the audio front end
  input wire logic mclk_err_i,
  input wire logic pll_err_i,
  input wire logic bclk_err_i,
  input wire logic fclk_err_i,
  input wire logic slip_err_i,
  input wire logic clip_i,
  input wire logic fault_i,
  // controls to the audio path
  output logic dc_block_en_o,
  output logic hard_unmute_o,
  output logic [1:0] deemph_o,
  output logic [1:0] fmt_family_o,
  output logic [4:0] fmt_word_len_o,
  output logic shutdown_o,
  output logic midz_ramp_en_o,
  output logic ternary_en_o,
  output logic [2:0] chan_quiet_o,
  // fault pin, two-way
  input wire logic fault_pin_i,
  output logic fault_pin_o,
  output logic fault_pin_oe_o,
  output logic addr_sel_o,
  // interrupt
  output logic irq_o
);
  import amp_regs_pkg::*;

  logic [6:0] ev_s1_r;
  logic [6:0] ev_s2_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic [7:0] err_r;
  logic [7:0] err_nxt;
  logic [7:0] irq_en_r;
  logic [7:0] filter_r;
  logic [7:0] format_r;
  logic [7:0] shdn_r;
  logic [7:0] quiet_r;
  logic ph_wr_r;
  logic ph_rd_r;
  logic [7:0] ph_idx_r;
  logic [7:0] ev_set;
  logic addr_take;
  logic [7:0] rd_byte;
  logic wr_err;
  logic wr_clr;

  // two-flop synchronisers for outside events and the pin
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ev_s1_r <= 7'h00;
      ev_s2_r <= 7'h00;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ev_s1_r <= {mclk_err_i, pll_err_i, bclk_err_i, fclk_err_i, slip_err_i, clip_i, fault_i};
      ev_s2_r <= ev_s1_r;
      pin_s1_r <= fault_pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  always_comb
  begin
    ev_set = 8'h00;
    ev_set[ERR_MCLK] = ev_s2_r[6];
    ev_set[ERR_PLL] = ev_s2_r[5];
    ev_set[ERR_BCLK] = ev_s2_r[4];
    ev_set[ERR_FCLK] = ev_s2_r[3];
    ev_set[ERR_SLIP] = ev_s2_r[2];
    ev_set[ERR_CLIP] = ev_s2_r[1];
    ev_set[ERR_FAULT] = ev_s2_r[0];
  end

  // bus address phase capture
  assign addr_take = hsel_i && hready_i && htrans_i[1];

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_idx_r <= 8'h00;
    end
    else if (clk_en_i)
    begin
      ph_wr_r <= addr_take && hwrite_i;
      ph_rd_r <= addr_take && !hwrite_i;
      ph_idx_r <= haddr_i[9:2];
    end
  end

  assign wr_err = ph_wr_r && (ph_idx_r == IDX_ERRORS);
  assign wr_clr = ph_wr_r && (ph_idx_r == IDX_IRQ_CLEAR);

  // sticky flags, set wins over clear
  // host write of zero clears the bit
  always_comb
  begin
    err_nxt = err_r;
    if (wr_err)
      err_nxt = err_nxt & hwdata_i[7:0] & ERR_MASK;
    if (wr_clr)
      err_nxt = err_nxt & ~hwdata_i[7:0];
    err_nxt = err_nxt | ev_set;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      err_r <= RST_ERRORS;
    else if (clk_en_i)
      err_r <= err_nxt;
  end

  // control register writes
  // reserved bits masked, id not writable
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      filter_r <= RST_FILTER;
      format_r <= RST_FORMAT;
      shdn_r <= RST_SHUTDOWN;
      quiet_r <= RST_QUIET;
      irq_en_r <= 8'h00;
    end
    else if (clk_en_i && ph_wr_r)
    begin
      case (ph_idx_r)
        IDX_FILTER: filter_r <= hwdata_i[7:0] & FLT_MASK;
        IDX_FORMAT:
        begin
          if ((hwdata_i[3:0] & FMT_MASK[3:0]) <= FMT_MAX)
            format_r <= {4'h0, hwdata_i[3:0]};
        end
        IDX_SHUTDOWN: shdn_r <= hwdata_i[7:0] & SHD_MASK;
        IDX_QUIET: quiet_r <= hwdata_i[7:0] & QUIET_MASK;
        IDX_IRQ_ENABLE: irq_en_r <= hwdata_i[7:0] & ERR_MASK;
        default: ;
      endcase
    end
  end

  // read mux on the address phase
  always_comb
  begin
    case (haddr_i[9:2])
      IDX_IDENT: rd_byte = IDENT_VALUE;
      IDX_ERRORS: rd_byte = err_nxt;
      IDX_FILTER: rd_byte = filter_r;
      IDX_FORMAT: rd_byte = format_r;
      IDX_SHUTDOWN: rd_byte = shdn_r;
      IDX_QUIET: rd_byte = quiet_r;
      IDX_IRQ_STATUS: rd_byte = err_nxt;
      IDX_IRQ_ENABLE: rd_byte = irq_en_r;
      default: rd_byte = 8'h00;
    endcase
    // a write in its data phase is seen by a read right behind it
    if (ph_wr_r && (ph_idx_r == haddr_i[9:2]))
    begin
      case (ph_idx_r)
        IDX_FILTER: rd_byte = hwdata_i[7:0] & FLT_MASK;
        IDX_FORMAT:
        begin
          if (hwdata_i[3:0] <= FMT_MAX)
            rd_byte = {4'h0, hwdata_i[3:0]};
        end
        IDX_SHUTDOWN: rd_byte = hwdata_i[7:0] & SHD_MASK;
        IDX_QUIET: rd_byte = hwdata_i[7:0] & QUIET_MASK;
        IDX_IRQ_ENABLE: rd_byte = hwdata_i[7:0] & ERR_MASK;
        default: ;
      endcase
    end
  end

  // bus answer, zero wait states
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // hrdata registered, valid in the cycle after the address phase
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      hrdata_o <= 32'h0000_0000;
    else if (clk_en_i && addr_take && !hwrite_i)
      hrdata_o <= {24'h000000, rd_byte};
  end

  // decoded controls
  // dc-block, unmute, de-emphasis, shutdown, mid-z, ternary, quiet and irq outputs
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      dc_block_en_o <= RST_FILTER[FLT_DCBLOCK];
      hard_unmute_o <= 1'b0;
      deemph_o <= DEEMPH_NONE;
      shutdown_o <= RST_SHUTDOWN[SHD_SHUTDOWN];
      midz_ramp_en_o <= 1'b0;
      ternary_en_o <= 1'b0;
      chan_quiet_o <= 3'h0;
      irq_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      dc_block_en_o <= filter_r[FLT_DCBLOCK];
      hard_unmute_o <= filter_r[FLT_HARDUNMUTE];
      deemph_o <= filter_r[1:0];
      shutdown_o <= shdn_r[SHD_SHUTDOWN];
      midz_ramp_en_o <= shdn_r[SHD_MIDZ];
      ternary_en_o <= shdn_r[SHD_TERNARY];
      chan_quiet_o <= quiet_r[2:0];
      irq_o <= |(err_nxt & irq_en_r);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      fmt_family_o <= FMT_I2S;
      fmt_word_len_o <= 5'd24;
    end
    else if (clk_en_i)
    begin
      case (format_r[3:0])
        4'h0: {fmt_family_o, fmt_word_len_o} <= {FMT_RIGHT, 5'd16};
        4'h1: {fmt_family_o, fmt_word_len_o} <= {FMT_RIGHT, 5'd20};
        4'h2: {fmt_family_o, fmt_word_len_o} <= {FMT_RIGHT, 5'd24};
        4'h3: {fmt_family_o, fmt_word_len_o} <= {FMT_I2S, 5'd16};
        4'h4: {fmt_family_o, fmt_word_len_o} <= {FMT_I2S, 5'd20};
        4'h6: {fmt_family_o, fmt_word_len_o} <= {FMT_LEFT, 5'd16};
        4'h7: {fmt_family_o, fmt_word_len_o} <= {FMT_LEFT, 5'd20};
        4'h8: {fmt_family_o, fmt_word_len_o} <= {FMT_LEFT, 5'd24};
        default: {fmt_family_o, fmt_word_len_o} <= {FMT_I2S, 5'd24};
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      fault_pin_oe_o <= 1'b0;
      fault_pin_o <= 1'b0;
      addr_sel_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      fault_pin_oe_o <= shdn_r[SHD_FAULTOUT];
      fault_pin_o <= ev_s2_r[0];
      if (!shdn_r[SHD_FAULTOUT])
        addr_sel_o <= pin_s2_r;
    end
  end

  // sticky flag holds while no clear write
  sticky_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_en_i && !wr_err && !wr_clr) |=> ((err_r & $past(err_r)) == $past(err_r)))
    else $error("error flag dropped without clear");

  mclk_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_en_i && mclk_err_i) ##1 clk_en_i ##1 clk_en_i |=> err_r[ERR_MCLK])
    else $error("mclk flag not set");

  bclk_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_en_i && ev_s2_r[4]) |=> err_r[ERR_BCLK])
    else $error("bclk flag not set");

  fclk_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_en_i && ev_s2_r[3]) |=> err_r[ERR_FCLK])
    else $error("fclk flag not set");

  slip_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_en_i && ev_s2_r[2]) |=> err_r[ERR_SLIP])
    else $error("slip flag not set");

  misc_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_en_i && ev_s2_r[5]) |=> err_r[ERR_PLL] && !err_r[0])
    else $error("pll flag not set");

  clip_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_en_i && ev_s2_r[1]) |=> err_r[ERR_CLIP])
    else $error("clip flag not set");

  fault_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_en_i && ev_s2_r[0]) |=> err_r[ERR_FAULT])
    else $error("fault flag not set");

  addr_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (clk_en_i && shdn_r[SHD_FAULTOUT]) |=> $stable(addr_sel_o))
    else $error("address select moved while driving");

  dcblock_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i |=> dc_block_en_o == $past(filter_r[FLT_DCBLOCK]))
    else $error("dc-block output wrong");

  shutdown_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i |=> shutdown_o == $past(shdn_r[SHD_SHUTDOWN]))
    else $error("shutdown output wrong");

  pin_dir_a: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i |=> fault_pin_oe_o == $past(shdn_r[SHD_FAULTOUT]))
    else $error("fault pin direction wrong");

  format_legal_a: assert property (@(posedge clk_i) disable iff (reset_i)
    format_r[3:0] <= FMT_MAX && format_r[7:4] == 4'h0)
    else $error("reserved format held");
endmodule : amp_control_status_regs
`default_nettype wire

// ==== testbench/ahb_host.sv ====
// ahb_host: host model issuing single-word ahb-lite transfers
// assumes hready fed back from the slave's hreadyout
`timescale 1ns/1ps
`default_nettype none
module ahb_host
(
  // bus side
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  initial
  begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end

  // one transfer, called just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] idx, d, output logic [7:0] q);
    hsel_o <= 1'b1;
    haddr_o <= {22'h0, idx, 2'h0};
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= {24'h0, d};
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i[7:0];
  endtask : xfer
endmodule : ahb_host
`default_nettype wire

// ==== testbench/tb_top.sv ====
// tb_top: self-checking bench for the amplifier control registers
// assumes the host model ahb_host and the package amp_regs_pkg
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import amp_regs_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en = 1'b1;
  logic [6:0] ev = 7'h0;
  logic pin_drv = 1'b1;
  logic [7:0] m [0:6];
  logic [7:0] ix [0:2] = '{8'h03, 8'h05, 8'h06};
  logic [7:0] mk [0:2] = '{FLT_MASK, SHD_MASK, QUIET_MASK};
  logic [7:0] q;
  logic [7:0] r;
  int errors = 0;
  int total_checks = 0;
  wire logic hsel, hwrite, hready, hresp, dc, hu, shd, midz, tern, fp_o, fp_oe, asel, irq;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0] htrans, deemph, fam;
  wire logic [2:0] hsize, quiet;
  wire logic [4:0] wlen;
  wire logic pin = fp_oe ? fp_o : pin_drv;
  wire logic [10:0] ctl_pins = {dc, hu, deemph, shd, midz, tern, fp_oe, quiet};
  wire logic [6:0] fmt_pins = {fam, wlen};

  always #10 clk_i = ~clk_i;

  ahb_host u_host (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));

  amp_control_status_regs u_amp_control_status_regs (.clk_i(clk_i), .reset_i(reset_i),
    .clk_en_i(clk_en), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .mclk_err_i(ev[6]), .pll_err_i(ev[5]),
    .bclk_err_i(ev[4]), .fclk_err_i(ev[3]), .slip_err_i(ev[2]), .clip_i(ev[1]),
    .fault_i(ev[0]), .dc_block_en_o(dc), .hard_unmute_o(hu), .deemph_o(deemph),
    .fmt_family_o(fam), .fmt_word_len_o(wlen), .shutdown_o(shd), .midz_ramp_en_o(midz),
    .ternary_en_o(tern), .chan_quiet_o(quiet), .fault_pin_i(pin), .fault_pin_o(fp_o),
    .fault_pin_oe_o(fp_oe), .addr_sel_o(asel), .irq_o(irq));

  function automatic logic [10:0] ctl(input logic [7:0] f, s, c);
    return {f[7], f[5], f[1:0], s[6], s[7], s[3], s[1], c[2:0]};
  endfunction : ctl

  function automatic logic [6:0] fmt(input logic [3:0] c);
    return {2'(c / 4'h3), 5'(5'd16 + 5'd4 * (c % 4'h3))};
  endfunction : fmt

  task automatic check_reg(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: register read %h expected %h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_pin(input logic [10:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: pins %h expected %h", $time, got, exp);
    end
  endtask : check_pin

  task automatic wr(input logic [7:0] idx, d);
    u_host.xfer(1'b1, idx, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, exp);
    u_host.xfer(1'b0, idx, 8'h00, q);
    check_reg(q, exp);
    check_pin({9'h0, hresp, |hrdata[31:8]}, 11'h0);
  endtask : rd_chk

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial
  begin
    #100000;
    errors++;
    stop_test;
  end

  initial
  begin
    void'($urandom(19));
    m = '{8'h00, IDENT_VALUE, RST_ERRORS, RST_FILTER, RST_FORMAT, RST_SHUTDOWN, RST_QUIET};
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 1; i < 7; i++) rd_chk(8'(i), m[i]);
    check_pin(ctl_pins, ctl(m[3], m[5], m[6]));
    check_pin({4'h0, fmt_pins}, {4'h0, fmt(m[4][3:0])});
    // every format code, reserved ones ignored
    for (int c = 0; c < 16; c++)
    begin
      r = 8'($urandom());
      wr(8'h04, {r[7:4], 4'(c)});
      if (c < 9) m[4] = 8'(c);
      rd_chk(8'h04, m[4]);
      repeat (3) @(posedge clk_i);
      check_pin({4'h0, fmt_pins}, {4'h0, fmt(m[4][3:0])});
    end
    // first passes set ternary while still shut down
    for (int i = 0; i < 15; i++)
    begin
      r = (i < 3) ? 8'hff : 8'($urandom());
      pin_drv <= r[0];
      wr(ix[i % 3], r);
      m[ix[i % 3]] = r & mk[i % 3];
      rd_chk(ix[i % 3], m[ix[i % 3]]);
      repeat (3) @(posedge clk_i);
      check_pin(ctl_pins, ctl(m[3], m[5], m[6]));
    end
    // pin as input: address select follows the pin level
    wr(IDX_SHUTDOWN, RST_SHUTDOWN);
    for (int i = 0; i < 4; i++)
    begin
      pin_drv <= !i[0];
      repeat (5) @(posedge clk_i);
      check_pin({8'h0, asel, fp_oe, fp_o}, {8'h0, !i[0], 2'b00});
    end
    // pin as output: latch held, fault level driven out
    wr(IDX_SHUTDOWN, RST_SHUTDOWN | 8'h02);
    ev[0] <= 1'b1;
    repeat (5) @(posedge clk_i);
    check_pin({8'h0, asel, fp_oe, fp_o}, 11'h003);
    // clearing while the fault persists keeps its flag
    wr(IDX_ERRORS, 8'h00);
    rd_chk(IDX_ERRORS, 8'h02);
    ev <= 7'h0;
    repeat (5) @(posedge clk_i);
    check_pin({8'h0, asel, fp_oe, fp_o}, 11'h002);
    wr(IDX_ERRORS, 8'h00);
    rd_chk(IDX_ERRORS, 8'h00);
    // event while the clock enable is low is missed
    clk_en <= 1'b0;
    ev[1] <= 1'b1;
    repeat (4) @(posedge clk_i);
    ev <= 7'h0;
    repeat (3) @(posedge clk_i);
    clk_en <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_chk(IDX_ERRORS, 8'h00);
    wr(8'h01, 8'h5a);
    rd_chk(8'h01, IDENT_VALUE);
    rd_chk(8'h3f, 8'h00);
    wr(IDX_IRQ_ENABLE, ERR_MASK);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7) wr(IDX_IRQ_ENABLE, 8'h00);
      ev[i % 7] <= 1'b1;
      repeat (3) @(posedge clk_i);
      ev <= 7'h0;
      repeat (6) @(posedge clk_i);
      // flag held after cause is gone
      rd_chk(IDX_ERRORS, 8'h02 << (i % 7));
      rd_chk(IDX_IRQ_STATUS, 8'h02 << (i % 7));
      check_pin({10'h0, irq}, {10'h0, (i < 7)});
      // clear with zeros or through the clear register, then reread
      if (i % 2 == 1)
        wr(IDX_IRQ_CLEAR, 8'hff);
      else
        wr(IDX_ERRORS, 8'h00);
      rd_chk(IDX_ERRORS, 8'h00);
      repeat (3) @(posedge clk_i);
      check_pin({10'h0, irq}, 11'h0);
    end
    // reset in mid-run brings back every default
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    m = '{8'h00, IDENT_VALUE, RST_ERRORS, RST_FILTER, RST_FORMAT, RST_SHUTDOWN, RST_QUIET};
    for (int i = 1; i < 7; i++) rd_chk(8'(i), m[i]);
    rd_chk(IDX_IRQ_ENABLE, 8'h00);
    check_pin(ctl_pins, ctl(m[3], m[5], m[6]));
    check_pin({4'h0, fmt_pins}, {4'h0, fmt(m[4][3:0])});
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
